// >>> dpc_top.sv
// DDR2 pin-level command, data mask, strobe and termination logic
`timescale 1ns/10ps
// Notes on behaviour
// [R1] A write beat whose mask is high with it is not stored.
// [R2] One mask value is taken per data beat, on each strobe edge; the code takes one per rising link clock edge only.
// [R3] On x8 the extended mode register makes the mask pin a read strobe.
// [R4] Bank address selects the bank for activate, read, write, precharge.
// [R5] Bank address during mode set picks base or extended register.
// [R6] Address carries row on activate, column and auto-precharge on access; the code does not use the row, since activate only marks the bank open.
// [R7] Address bit 10 on precharge closes one bank when low, all when high.
// [R8] Single-bank precharge closes only the bank named by bank address.
// [R9] Address carries the opcode loaded by a mode register set.
// [R10] Read strobe edges align with data; write strobe is centred by host.
// [R11] On x16 the lower strobe times lanes 0-7, the upper lanes 8-15.
// [R12] On x8 with the option set, a read strobe leaves on the mask pin.
// [R13] Termination covers data, strobes and masks, both pairs only on x16.
// [R14] A command is decoded from the select and command pins on one edge.
// [R15] Commands are ignored while chip select is high.
// [R16] Command codes follow the usual DDR2 truth table.
module dpc_top (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_link_clk,
   input wire logic [1:0] i_org,
   input wire logic i_cs_n,
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   input wire logic i_we_n,
   input wire logic [dpc_pkg::BA_W-1:0] i_ba,
   input wire logic [dpc_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_odt,
   input wire logic [dpc_pkg::DQ_W-1:0] i_dq,
   input wire logic [dpc_pkg::LANES-1:0] i_dm,
   output logic [dpc_pkg::DQ_W-1:0] o_dq,
   output logic [dpc_pkg::LANES-1:0] o_dq_oe,
   output logic [dpc_pkg::LANES-1:0] o_dqs,
   output logic [dpc_pkg::LANES-1:0] o_dqs_oe,
   output logic [dpc_pkg::LANES-1:0] o_dqs_n,
   output logic [dpc_pkg::LANES-1:0] o_dqs_n_oe,
   output logic o_rdqs,
   output logic o_rdqs_oe,
   output logic o_burst_active,
   output logic [dpc_pkg::BANKS-1:0] o_bank_open,
   output logic o_term_dq,
   output logic [dpc_pkg::LANES-1:0] o_term_dqs,
   output logic [dpc_pkg::LANES-1:0] o_term_dm
);
   ////////////////////////////////////////////////////////////////////////
   dpc_cmd_if cmd_bus ();

   dpc_cmd_decode u_decode (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_cs_n(i_cs_n),
      .i_ras_n(i_ras_n),
      .i_cas_n(i_cas_n),
      .i_we_n(i_we_n),
      .i_ba(i_ba),
      .i_addr(i_addr),
      .i_odt(i_odt),
      .cmd_bus(cmd_bus)
   );

   ////////////////////////////////////////////////////////////////////////
   // Core domain: mode registers, bank state, burst requests
   logic [1:0] org_s1_q;
   logic [1:0] org_s2_q;
   logic [dpc_pkg::ADDR_W-1:0] mr_q;
   logic [dpc_pkg::ADDR_W-1:0] emr1_q;
   logic [dpc_pkg::BANKS-1:0] open_q;
   dpc_pkg::dpc_req_s req_q;
   logic req_tgl_q;
   logic ack_s1_q;
   logic ack_s2_q;
   logic busy;
   logic is_x8;
   logic is_x16;
   logic access;
   logic accept;
   logic odt_on;
   logic ack_tgl_q;

   // Organisation strap is static, only synchronised
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         org_s1_q <= 2'h0;
         org_s2_q <= 2'h0;
      end else begin
         org_s1_q <= i_org;
         org_s2_q <= org_s1_q;
      end
   end

   assign is_x8 = org_s2_q == dpc_pkg::ORG_X8;
   assign is_x16 = org_s2_q == dpc_pkg::ORG_X16;
   assign busy = req_tgl_q != ack_s2_q;
   assign access = cmd_bus.cmd == dpc_pkg::CMD_RD ||
                   cmd_bus.cmd == dpc_pkg::CMD_WR;
   // Access to a closed bank or during a burst is dropped
   assign accept = access && open_q[cmd_bus.ba] && !busy; // R4

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mr_q <= dpc_pkg::MR_RST;
         emr1_q <= dpc_pkg::EMR1_RST;
      end else if (cmd_bus.cmd == dpc_pkg::CMD_MRS) begin
         if (cmd_bus.ba == dpc_pkg::SEL_MR) begin // R5
            mr_q <= cmd_bus.addr; // R9
         end
         if (cmd_bus.ba == dpc_pkg::SEL_EMR1) begin // R5
            emr1_q <= cmd_bus.addr; // R9
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         open_q <= '0;
      end else begin
         unique case (cmd_bus.cmd)
            dpc_pkg::CMD_ACT: open_q[cmd_bus.ba] <= 1'b1; // R4
            dpc_pkg::CMD_PRE: begin
               if (cmd_bus.addr[dpc_pkg::PRE_ALL_BIT]) begin // R7
                  open_q <= '0;
               end else begin
                  open_q[cmd_bus.ba] <= 1'b0; // R8
               end
            end
            dpc_pkg::CMD_RD, dpc_pkg::CMD_WR: begin
               if (accept && cmd_bus.addr[dpc_pkg::AUTO_PRE_BIT]) begin // R6
                  open_q[cmd_bus.ba] <= 1'b0;
               end
            end
            dpc_pkg::CMD_NOP, dpc_pkg::CMD_REF, dpc_pkg::CMD_MRS,
            dpc_pkg::CMD_BST: open_q <= open_q;
         endcase
      end
   end

   // Request word is held stable until the link side acknowledges
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         req_q <= '0;
         req_tgl_q <= 1'b0;
      end else if (accept) begin
         req_q.wr <= cmd_bus.cmd == dpc_pkg::CMD_WR;
         req_q.ba <= cmd_bus.ba; // R4
         req_q.col <= cmd_bus.addr[dpc_pkg::COL_W-1:0]; // R6
         req_q.bl8 <= mr_q[dpc_pkg::MR_BL_LSB +: 3] == dpc_pkg::MR_BL8;
         req_q.mask_en <= !(is_x8 && emr1_q[dpc_pkg::EMR1_RDQS_BIT]); // R3
         req_q.rdqs <= is_x8 && emr1_q[dpc_pkg::EMR1_RDQS_BIT]; // R12
         req_q.x16 <= is_x16;
         req_q.dqsn_en <= !emr1_q[dpc_pkg::EMR1_DQSN_DIS_BIT];
         req_tgl_q <= !req_tgl_q;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
      end else begin
         ack_s1_q <= ack_tgl_q;
         ack_s2_q <= ack_s1_q;
      end
   end

   // Termination released while the device drives read data
   assign odt_on = cmd_bus.odt && !(busy && !req_q.wr) &&
                   (emr1_q[dpc_pkg::EMR1_RTT0_BIT] ||
                    emr1_q[dpc_pkg::EMR1_RTT1_BIT]);

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_term_dq <= 1'b0;
         o_term_dqs <= '0;
         o_term_dm <= '0;
      end else begin
         o_term_dq <= odt_on; // R13
         o_term_dqs <= {odt_on && is_x16, odt_on}; // R13
         o_term_dm <= {odt_on && is_x16, odt_on}; // R13
      end
   end

   assign o_bank_open = open_q;

   ////////////////////////////////////////////////////////////////////////
   // Link domain: beat engine on the strobe clock
   logic lrst_s1_q;
   logic lrst_n_q;
   logic rq_s1_q;
   logic rq_s2_q;
   logic rq_s3_q;
   dpc_pkg::dpc_lk_e lk_q;
   dpc_pkg::dpc_req_s lreq_q;
   logic [3:0] beat_q;
   logic [dpc_pkg::COL_W-1:0] col_q;
   logic [dpc_pkg::BA_W+dpc_pkg::COL_W-1:0] idx;
   logic [dpc_pkg::DQ_W-1:0] rd_data;
   logic [dpc_pkg::LANES-1:0] lane_we;
   logic last_beat;
   logic dqs_q;
   logic [dpc_pkg::LANES-1:0] dqs_oe_q;

   always_ff @(posedge i_link_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lrst_s1_q <= 1'b0;
         lrst_n_q <= 1'b0;
      end else begin
         lrst_s1_q <= 1'b1;
         lrst_n_q <= lrst_s1_q;
      end
   end

   always_ff @(posedge i_link_clk or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         rq_s1_q <= 1'b0;
         rq_s2_q <= 1'b0;
         rq_s3_q <= 1'b0;
      end else begin
         rq_s1_q <= req_tgl_q;
         rq_s2_q <= rq_s1_q;
         rq_s3_q <= rq_s2_q;
      end
   end

   assign idx = {lreq_q.ba, col_q};
   assign last_beat = beat_q == (lreq_q.bl8 ? dpc_pkg::LAST_BEAT_BL8 :
                                 dpc_pkg::LAST_BEAT_BL4);

   always_ff @(posedge i_link_clk or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         lk_q <= dpc_pkg::LK_IDLE;
         lreq_q <= '0;
         beat_q <= 4'h0;
         col_q <= '0;
         ack_tgl_q <= 1'b0;
      end else begin
         unique case (lk_q)
            dpc_pkg::LK_IDLE: begin
               if (rq_s2_q != rq_s3_q) begin
                  lreq_q <= req_q;
                  col_q <= req_q.col;
                  beat_q <= 4'h0;
                  lk_q <= req_q.wr ? dpc_pkg::LK_WRITE : dpc_pkg::LK_READ;
               end
            end
            dpc_pkg::LK_WRITE, dpc_pkg::LK_READ: begin
               // Burst wraps within its own aligned block
               col_q <= lreq_q.bl8 ? {col_q[3], col_q[2:0] + 3'h1} :
                                     {col_q[3:2], col_q[1:0] + 2'h1};
               beat_q <= beat_q + 4'h1; // R2
               if (last_beat) begin
                  ack_tgl_q <= !ack_tgl_q;
                  lk_q <= dpc_pkg::LK_IDLE;
               end
            end
         endcase
      end
   end

   // Each lane keeps its own store, written only when unmasked
   for (genvar g = 0; g < dpc_pkg::LANES; g++) begin : g_lane
      logic [7:0] mem [2**(dpc_pkg::BA_W+dpc_pkg::COL_W)];
      logic masked;
      assign masked = lreq_q.mask_en && (lreq_q.x16 ? i_dm[g] : i_dm[0]);
      assign lane_we[g] = lk_q == dpc_pkg::LK_WRITE && !masked && // R1
                          (g == 0 || lreq_q.x16);
      always_ff @(posedge i_link_clk) begin
         if (lane_we[g]) begin
            mem[idx] <= i_dq[g*8 +: 8]; // R2
         end
      end
      assign rd_data[g*8 +: 8] = mem[idx];
   end

   // Data and strobe change on the same edge, so edges align
   always_ff @(posedge i_link_clk or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         o_dq <= '0;
         o_dq_oe <= '0;
         dqs_q <= 1'b0;
         dqs_oe_q <= '0;
      end else if (lk_q == dpc_pkg::LK_READ) begin
         o_dq <= rd_data;
         o_dq_oe <= {lreq_q.x16, 1'b1};
         dqs_q <= !dqs_q; // R10
         dqs_oe_q <= {lreq_q.x16, 1'b1}; // R11
      end else begin
         o_dq_oe <= '0;
         dqs_q <= 1'b0;
         dqs_oe_q <= '0;
      end
   end

   assign o_dqs = {dpc_pkg::LANES{dqs_q}};
   assign o_dqs_oe = dqs_oe_q;
   assign o_dqs_n = ~o_dqs;
   assign o_dqs_n_oe = dqs_oe_q & {dpc_pkg::LANES{lreq_q.dqsn_en}};
   assign o_rdqs = dqs_q;
   assign o_rdqs_oe = dqs_oe_q[0] && lreq_q.rdqs; // R12
   assign o_burst_active = lk_q != dpc_pkg::LK_IDLE;

   ////////////////////////////////////////////////////////////////////////
   property p_pre_all;
      @(posedge i_clock) disable iff (!i_rst_n)
      cmd_bus.cmd == dpc_pkg::CMD_PRE && cmd_bus.addr[10] |=> open_q == '0;
   endproperty
   a_pre_all: assert property (p_pre_all) // R7
      else $error("precharge all left a bank open");

   property p_pre_one;
      @(posedge i_clock) disable iff (!i_rst_n)
      cmd_bus.cmd == dpc_pkg::CMD_PRE && !cmd_bus.addr[10]
      |=> !open_q[$past(cmd_bus.ba)] &&
          ((open_q | (4'h1 << $past(cmd_bus.ba))) ==
           ($past(open_q) | (4'h1 << $past(cmd_bus.ba))));
   endproperty
   a_pre_one: assert property (p_pre_one) // R8
      else $error("single precharge touched the wrong banks");

   property p_act;
      @(posedge i_clock) disable iff (!i_rst_n)
      cmd_bus.cmd == dpc_pkg::CMD_ACT |=> open_q[$past(cmd_bus.ba)];
   endproperty
   a_act: assert property (p_act) // R4
      else $error("activate did not open its bank");

   property p_emr1_load;
      @(posedge i_clock) disable iff (!i_rst_n)
      cmd_bus.cmd == dpc_pkg::CMD_MRS && cmd_bus.ba == 2'h1
      |=> emr1_q == $past(cmd_bus.addr) && $stable(mr_q);
   endproperty
   a_emr1_load: assert property (p_emr1_load) // R5
      else $error("extended mode set went to the wrong register");

   property p_rdqs_no_mask;
      @(posedge i_clock) disable iff (!i_rst_n)
      accept && is_x8 && emr1_q[11] |=> !req_q.mask_en && req_q.rdqs;
   endproperty
   a_rdqs_no_mask: assert property (p_rdqs_no_mask) // R3
      else $error("mask pin still masking in read strobe mode");

   property p_mask_drop;
      @(posedge i_link_clk) disable iff (!lrst_n_q)
      lk_q == dpc_pkg::LK_WRITE && lreq_q.mask_en && i_dm[0]
      |-> !lane_we[0];
   endproperty
   a_mask_drop: assert property (p_mask_drop) // R1
      else $error("masked beat was written");

   property p_beat_step;
      @(posedge i_link_clk) disable iff (!lrst_n_q)
      lk_q == dpc_pkg::LK_WRITE && !last_beat
      |=> lk_q == dpc_pkg::LK_WRITE && beat_q == $past(beat_q) + 4'h1;
   endproperty
   a_beat_step: assert property (p_beat_step) // R2
      else $error("write beat not advanced on the edge");

   property p_edge_align;
      @(posedge i_link_clk) disable iff (!lrst_n_q)
      $rose(o_dq_oe[0]) |-> o_dqs[0] ##1 (!o_dq_oe[0] || !o_dqs[0]);
   endproperty
   a_edge_align: assert property (p_edge_align) // R10
      else $error("read strobe not toggling with data");

   property p_upper_strobe;
      @(posedge i_link_clk) disable iff (!lrst_n_q)
      o_dqs_oe[1] |-> lreq_q.x16 && o_dq_oe[1];
   endproperty
   a_upper_strobe: assert property (p_upper_strobe) // R11
      else $error("upper strobe driven outside x16 lane use");

   property p_term_x16;
      @(posedge i_clock) disable iff (!i_rst_n)
      o_term_dm[1] || o_term_dqs[1] |-> $past(is_x16) && o_term_dq;
   endproperty
   a_term_x16: assert property (p_term_x16) // R13
      else $error("upper termination outside x16");

   c_write: cover property (@(posedge i_link_clk) disable iff (!lrst_n_q)
      lk_q == dpc_pkg::LK_WRITE && last_beat);
   c_read_rdqs: cover property (@(posedge i_link_clk)
      disable iff (!lrst_n_q) o_rdqs_oe);
   c_pre_all: cover property (@(posedge i_clock) disable iff (!i_rst_n)
      cmd_bus.cmd == dpc_pkg::CMD_PRE && cmd_bus.addr[10]);
endmodule

// >>> dpc_pkg.sv
// Constants, types and encodings shared by the pin command block
package dpc_pkg;

   localparam int BA_W = 2;
   localparam int ADDR_W = 14;
   localparam int DQ_W = 16;
   localparam int LANES = 2;
   localparam int BANKS = 4;
   localparam int COL_W = 4;
   localparam int PIN_W = 21;

   // Pin vector layout: {odt, cs_n, ras_n, cas_n, we_n, ba, addr}
   localparam int PIN_ADDR_LSB = 0;
   localparam int PIN_BA_LSB = 14;
   localparam int PIN_WE_BIT = 16;
   localparam int PIN_CAS_BIT = 17;
   localparam int PIN_RAS_BIT = 18;
   localparam int PIN_CS_BIT = 19;
   localparam int PIN_ODT_BIT = 20;
   // Strobes deselected, so reset never decodes as a command
   localparam logic [PIN_W-1:0] PIN_RST = 21'h0f0000;

   localparam int PRE_ALL_BIT = 10;
   localparam int AUTO_PRE_BIT = 10;
   localparam int EMR1_RDQS_BIT = 11;
   localparam int EMR1_DQSN_DIS_BIT = 10;
   localparam int EMR1_RTT0_BIT = 2;
   localparam int EMR1_RTT1_BIT = 6;
   localparam int MR_BL_LSB = 0;
   localparam logic [2:0] MR_BL8 = 3'h3;

   localparam logic [BA_W-1:0] SEL_MR = 2'h0;
   localparam logic [BA_W-1:0] SEL_EMR1 = 2'h1;
   localparam logic [ADDR_W-1:0] MR_RST = 14'h0002;
   localparam logic [ADDR_W-1:0] EMR1_RST = 14'h0000;

   localparam logic [3:0] LAST_BEAT_BL4 = 4'h3;
   localparam logic [3:0] LAST_BEAT_BL8 = 4'h7;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS, CMD_BST
   } dpc_cmd_e;

   typedef enum logic [1:0] {ORG_X4, ORG_X8, ORG_X16} dpc_org_e;

   typedef enum logic [1:0] {LK_IDLE, LK_WRITE, LK_READ} dpc_lk_e;

   typedef struct packed {
      logic wr;
      logic [BA_W-1:0] ba;
      logic [COL_W-1:0] col;
      logic bl8;
      logic mask_en;
      logic rdqs;
      logic x16;
      logic dqsn_en;
   } dpc_req_s;

endpackage

// >>> dpc_cmd_if.sv
// Decoded command bundle between pin decoder and core
`timescale 1ns/10ps
interface dpc_cmd_if;
   dpc_pkg::dpc_cmd_e cmd;
   logic [dpc_pkg::BA_W-1:0] ba;
   logic [dpc_pkg::ADDR_W-1:0] addr;
   logic odt;
   modport dec (output cmd, output ba, output addr, output odt);
   modport core (input cmd, input ba, input addr, input odt);
endinterface

// >>> dpc_cmd_decode.sv
// Pin synchroniser and command decoder
`timescale 1ns/10ps
module dpc_cmd_decode (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_cs_n,
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   input wire logic i_we_n,
   input wire logic [dpc_pkg::BA_W-1:0] i_ba,
   input wire logic [dpc_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_odt,
   dpc_cmd_if.dec cmd_bus
);
   logic [dpc_pkg::PIN_W-1:0] pin_s1_q;
   logic [dpc_pkg::PIN_W-1:0] pin_s2_q;
   dpc_pkg::dpc_cmd_e cmd_d;
   dpc_pkg::dpc_cmd_e cmd_q;
   logic [dpc_pkg::BA_W-1:0] ba_q;
   logic [dpc_pkg::ADDR_W-1:0] addr_q;
   logic odt_q;

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_s1_q <= dpc_pkg::PIN_RST;
         pin_s2_q <= dpc_pkg::PIN_RST;
      end else begin
         pin_s1_q <= {i_odt, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr};
         pin_s2_q <= pin_s1_q;
      end
   end

   // All four command pins judged from the same sampled edge
   always_comb begin
      cmd_d = dpc_pkg::CMD_NOP;
      if (!pin_s2_q[dpc_pkg::PIN_CS_BIT]) begin // R15
         unique case (pin_s2_q[dpc_pkg::PIN_WE_BIT +: 3]) // R14
            3'h3: cmd_d = dpc_pkg::CMD_ACT; // R16
            3'h5: cmd_d = dpc_pkg::CMD_RD;
            3'h4: cmd_d = dpc_pkg::CMD_WR;
            3'h2: cmd_d = dpc_pkg::CMD_PRE;
            3'h1: cmd_d = dpc_pkg::CMD_REF;
            3'h0: cmd_d = dpc_pkg::CMD_MRS;
            3'h6: cmd_d = dpc_pkg::CMD_BST;
            3'h7: cmd_d = dpc_pkg::CMD_NOP;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_q <= dpc_pkg::CMD_NOP;
         ba_q <= '0;
         addr_q <= '0;
         odt_q <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         ba_q <= pin_s2_q[dpc_pkg::PIN_BA_LSB +: dpc_pkg::BA_W];
         addr_q <= pin_s2_q[dpc_pkg::PIN_ADDR_LSB +: dpc_pkg::ADDR_W];
         odt_q <= pin_s2_q[dpc_pkg::PIN_ODT_BIT];
      end
   end

   assign cmd_bus.cmd = cmd_q;
   assign cmd_bus.ba = ba_q;
   assign cmd_bus.addr = addr_q;
   assign cmd_bus.odt = odt_q;

   property p_cs_masks;
      @(posedge i_clock) disable iff (!i_rst_n)
      pin_s2_q[dpc_pkg::PIN_CS_BIT] |=> cmd_q == dpc_pkg::CMD_NOP;
   endproperty
   a_cs_masks: assert property (p_cs_masks) // R15
      else $error("command decoded while deselected");

   property p_act_code;
      @(posedge i_clock) disable iff (!i_rst_n)
      (!pin_s2_q[dpc_pkg::PIN_CS_BIT] &&
       pin_s2_q[dpc_pkg::PIN_WE_BIT +: 3] == 3'h3)
      |=> cmd_q == dpc_pkg::CMD_ACT;
   endproperty
   a_act_code: assert property (p_act_code) // R14
      else $error("activate code not decoded");
endmodule

// >>> dpc_ctrl_model.sv
// Controller-side model: drives command pins and write beats
`timescale 1ns/10ps
module dpc_ctrl_model (
   input wire logic i_clock,
   input wire logic i_link_clk,
   input wire logic i_burst_active,
   output logic o_cs_n,
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_we_n,
   output logic [dpc_pkg::BA_W-1:0] o_ba,
   output logic [dpc_pkg::ADDR_W-1:0] o_addr,
   output logic o_odt,
   output logic [dpc_pkg::DQ_W-1:0] o_dq,
   output logic [dpc_pkg::LANES-1:0] o_dm
);
   logic [63:0] wdata;
   logic [7:0] wmask;
   logic wr_en;
   logic [2:0] beat;
   logic [17:0] last_q;
   initial begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
      o_ba = 2'h0;
      o_addr = 14'h0000;
      o_odt = 1'b0;
      {wdata, wmask, wr_en, beat, last_q} = '0;
   end
   ////////////////////////////////////////////////////////////////////
   // One command cycle, then a NOP so nothing repeats
   task automatic cmd(input logic cs_n, input logic [2:0] rcw,
                      input logic [1:0] ba, input logic [13:0] addr);
      @(posedge i_clock);
      o_cs_n <= cs_n;
      {o_ras_n, o_cas_n, o_we_n} <= rcw;
      o_ba <= ba;
      o_addr <= addr;
      @(posedge i_clock);
      {o_ras_n, o_cas_n, o_we_n} <= 3'h7;
   endtask
   task automatic set_odt(input logic v);
      @(posedge i_clock);
      o_odt <= v;
   endtask
   // Link clock stands in for the centred write strobe
   task automatic wburst(input logic [63:0] d, input logic [7:0] m);
      int n;
      @(posedge i_link_clk);
      wdata <= d;
      wmask <= m;
      wr_en <= 1'b1;
      for (n = 0; n < 40 && beat != 3'h4; n++) begin
         @(posedge i_link_clk);
      end
      wr_en <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////
   always @(posedge i_link_clk) begin
      // Beat counter has this one driver, cleared between bursts
      if (!wr_en) begin
         beat <= 3'h0;
      end else if (i_burst_active && beat < 3'h4) begin
         beat <= beat + 3'h1;
      end
      last_q <= {o_dm, o_dq};
   end
   // Released lines toggle so a stale beat cannot pass as fresh
   assign {o_dm, o_dq} = (wr_en && beat < 3'h4) ?
      {wmask[2*beat+:2], wdata[16*beat+:16]} : ~last_q;
endmodule

// >>> test_dpc_top.sv
// Self-checking bench for the pin command block
`timescale 1ns/10ps
module test_dpc_top;
   logic i_clock = 1'b0;
   logic i_link_clk = 1'b0;
   logic i_rst_n;
   logic [1:0] org;
   logic cs_n, ras_n, cas_n, we_n, odt, busy, rdqs_oe, term_dq, rdqs_seen;
   logic [1:0] ba, dm, dq_oe, dqs, dqs_oe, term_dqs, term_dm;
   logic [1:0] dqs_n, dqs_n_oe;
   logic rdqs;
   logic [13:0] addr;
   logic [15:0] dq, o_dq;
   logic [3:0] bank_open;
   int err_count, tests_run;
   always #4 i_clock = ~i_clock;
   always #7.5 i_link_clk = ~i_link_clk;
   dpc_top u_dpc_top (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_link_clk(i_link_clk), .i_org(org), .i_cs_n(cs_n),
      .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba),
      .i_addr(addr), .i_odt(odt), .i_dq(dq), .i_dm(dm), .o_dq(o_dq),
      .o_dq_oe(dq_oe), .o_dqs(dqs), .o_dqs_oe(dqs_oe), .o_dqs_n(dqs_n),
      .o_dqs_n_oe(dqs_n_oe), .o_rdqs(rdqs), .o_rdqs_oe(rdqs_oe),
      .o_burst_active(busy), .o_bank_open(bank_open),
      .o_term_dq(term_dq), .o_term_dqs(term_dqs), .o_term_dm(term_dm));
   dpc_ctrl_model u_dpc_ctrl_model (.i_clock(i_clock),
      .i_link_clk(i_link_clk), .i_burst_active(busy), .o_cs_n(cs_n),
      .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba),
      .o_addr(addr), .o_odt(odt), .o_dq(dq), .o_dm(dm));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [63:0] exp,
                        input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test;
      $display("tests %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Command, then settle past the sync and decode stages
   task automatic cmd(input logic cs, input logic [2:0] rcw,
                      input logic [1:0] b, input logic [13:0] a);
      u_dpc_ctrl_model.cmd(cs, rcw, b, a);
      repeat (6) @(posedge i_clock);
   endtask
   task automatic wr(input logic [63:0] d, input logic [7:0] m);
      u_dpc_ctrl_model.cmd(1'b0, 3'h4, 2'h1, 14'h0000);
      u_dpc_ctrl_model.wburst(d, m);
      repeat (12) @(posedge i_clock);
   endtask
   task automatic rd(input logic [63:0] exp, input logic [15:0] cmp);
      logic [63:0] got;
      logic [3:0] strb;
      int n, k;
      got = '0;
      strb = '0;
      k = 0;
      u_dpc_ctrl_model.cmd(1'b0, 3'h5, 2'h1, 14'h0000);
      for (n = 0; n < 60 && k < 4; n++) begin
         @(posedge i_link_clk);
         #1;
         if (rdqs_oe === 1'b1) begin
            rdqs_seen = 1'b1;
            check("mask pin strobe level", 64'(dqs[0]), 64'(rdqs));
         end
         if (dq_oe !== 2'h0) begin
            got[16*k+:16] = o_dq & cmp;
            strb[3-k] = dqs[0];
            k++;
            check("lane enables", 64'({cmp[8], 1'b1, cmp[8], 1'b1}),
                  64'({dq_oe, dqs_oe}));
            check("strobe pair", 64'({dqs_oe, ~dqs}),
                  64'({dqs_n_oe, dqs_n}));
         end
      end
      check("read data", exp & {4{cmp}}, got);
      check("read strobe", 64'ha, 64'(strb));
      repeat (12) @(posedge i_clock);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      check("idle outputs", 64'h0, 64'({bank_open, busy, dq_oe, dqs_oe,
         rdqs_oe, term_dq, term_dqs, term_dm}));
      $display("test reset done");
   endtask
   task automatic t_act;
      logic seen;
      seen = 1'b0;
      cmd(1'b0, 3'h3, 2'h1, 14'h1234);
      cmd(1'b0, 3'h3, 2'h2, 14'h0042);
      cmd(1'b1, 3'h3, 2'h3, 14'h0000);
      check("bank open", 64'h6, 64'(bank_open));
      u_dpc_ctrl_model.cmd(1'b0, 3'h5, 2'h3, 14'h0000);
      repeat (20) begin
         @(posedge i_clock);
         #1;
         if (busy !== 1'b0) seen = 1'b1;
      end
      check("closed bank read", 64'h0, 64'(seen));
      $display("test activate done");
   endtask
   task automatic t_mode;
      u_dpc_ctrl_model.set_odt(1'b1);
      cmd(1'b0, 3'h0, 2'h2, 14'h0004);
      check("term off", 64'h0, 64'({term_dq, term_dqs, term_dm}));
      cmd(1'b0, 3'h0, dpc_pkg::SEL_EMR1, 14'h0004);
      check("term x16", 64'h1f, 64'({term_dq, term_dqs, term_dm}));
      $display("test mode done");
   endtask
   task automatic t_data;
      wr(64'h4444_3333_2222_1111, 8'h00);
      wr(64'hdddd_cccc_bbbb_aaaa, 8'h24);
      rd(64'hdddd_33cc_bb22_aaaa, 16'hffff);
      $display("test data done");
   endtask
   task automatic t_pre;
      cmd(1'b0, 3'h2, 2'h1, 14'h0000);
      check("single close", 64'h4, 64'(bank_open));
      cmd(1'b0, 3'h3, 2'h0, 14'h0000);
      cmd(1'b0, 3'h2, 2'h0, 14'h0400);
      check("all close", 64'h0, 64'(bank_open));
      $display("test precharge done");
   endtask
   task automatic t_x8;
      cmd(1'b0, 3'h3, 2'h1, 14'h0000);
      @(posedge i_clock);
      org <= 2'h1;
      cmd(1'b0, 3'h0, dpc_pkg::SEL_EMR1, 14'h0804);
      check("term x8", 64'h15, 64'({term_dq, term_dqs, term_dm}));
      rd(64'hdddd_33cc_bb22_aaaa, 16'h00ff);
      check("mask pin strobe", 64'h1, 64'(rdqs_seen));
      $display("test x8 done");
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      err_count = 0;
      tests_run = 0;
      rdqs_seen = 1'b0;
      i_rst_n = 1'b0;
      org = 2'h2;
      repeat (3) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (8) @(posedge i_clock);
      t_reset;
      t_act;
      t_mode;
      t_data;
      t_pre;
      t_x8;
      finish_test;
   end
   // Whole run needs roughly 2 us
   initial begin
      #100000;
      err_count++;
      finish_test;
   end
endmodule
